// ==== design/sptmr_map.vh ====
/*
 sptmr_map.vh: register offsets, field positions and reset values of the split 16-bit timer.
 Assumes inclusion by bare name from the timer module.
*/
`ifndef SPTMR_MAP_VH
`define SPTMR_MAP_VH
// register byte offsets (APB, one aligned word each)
`define SPTMR_CFG_OFF 12'h000
`define SPTMR_AMODE_OFF 12'h004
`define SPTMR_BMODE_OFF 12'h008
`define SPTMR_CTL_OFF 12'h00C
`define SPTMR_IMR_OFF 12'h018
`define SPTMR_RIS_OFF 12'h01C
`define SPTMR_MIS_OFF 12'h020
`define SPTMR_ICR_OFF 12'h024
`define SPTMR_AILR_OFF 12'h028
`define SPTMR_BILR_OFF 12'h02C
`define SPTMR_AMATCH_OFF 12'h030
`define SPTMR_BMATCH_OFF 12'h034
`define SPTMR_APR_OFF 12'h038
`define SPTMR_BPR_OFF 12'h03C
`define SPTMR_APMR_OFF 12'h040
`define SPTMR_BPMR_OFF 12'h044
`define SPTMR_AR_OFF 12'h048
`define SPTMR_BR_OFF 12'h04C
// configuration value selecting split halves
`define SPTMR_CFG_SPLIT 3'h4
// half mode field values
`define SPTMR_MODE_ONESHOT 2'h1
`define SPTMR_MODE_PERIODIC 2'h2
`define SPTMR_MODE_CAPTURE 2'h3
// mode register fields: [1:0] mode, [2] capture mode, [3] alternate mode
`define SPTMR_MR_CMR 2
`define SPTMR_MR_AMS 3
// control register: half a in [7:0], half b in [15:8]
`define SPTMR_CTL_B_SHIFT 8
`define SPTMR_CTL_EN 0
`define SPTMR_CTL_STALL 1
`define SPTMR_CTL_EV_LO 2
`define SPTMR_CTL_OTE 5
`define SPTMR_CTL_PWML 6
// event select values
`define SPTMR_EV_RISE 2'h0
`define SPTMR_EV_FALL 2'h1
`define SPTMR_EV_BOTH 2'h3
// status bits: half a [2:0], half b [10:8]
`define SPTMR_ST_TO 0
`define SPTMR_ST_CM 1
`define SPTMR_ST_CE 2
`define SPTMR_ST_B_SHIFT 8
// reset values
`define SPTMR_CNT_RST 16'hFFFF
`define SPTMR_PRE_RST 8'h00
`endif

// ==== design/sptmr_timer.v ====
/*
 sptmr_timer.v: split 16-bit general timer unit with two halves, APB slave register file.
 Assumes capture pins synchronous-capable single-bit inputs, one clock pclk, APB3 master.
*/
`timescale 1ns/1ns
`include "sptmr_map.vh"
module sptmr_timer #(
   parameter CW = 16,
   parameter PW = 8
) (
   pclk,
   presetn,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   ccp_in,
   pwm_out,
   trig_out,
   irq
);
   input wire pclk;
   input wire presetn;
   input wire psel;
   input wire penable;
   input wire pwrite;
   input wire [11:0] paddr;
   input wire [31:0] pwdata;
   output reg [31:0] prdata;
   output wire pready;
   output wire pslverr;
   input wire [1:0] ccp_in;
   output wire [1:0] pwm_out;
   output reg [1:0] trig_out;
   output wire irq;

   reg [2:0] cfg_q;
   reg [3:0] mode_q [0:1];
   reg [7:0] ctl_q [0:1];
   reg [CW-1:0] ilr_q [0:1];
   reg [CW-1:0] match_q [0:1];
   reg [PW-1:0] pr_q [0:1];
   reg [PW-1:0] pmr_q [0:1];
   reg [CW-1:0] cnt_q [0:1];
   reg [PW-1:0] pre_q [0:1];
   reg [CW-1:0] cap_q [0:1];
   reg [1:0] ilr_new_q;
   reg [1:0] pwm_q;
   reg [10:0] ris_q;
   reg [10:0] imr_q;
   reg [1:0] sync1_q;
   reg [1:0] sync2_q;
   reg [1:0] prev_q;

   wire wr = psel & penable & pwrite;
   wire [10:0] mis = ris_q & imr_q;
   wire split = (cfg_q == `SPTMR_CFG_SPLIT);

   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign irq = |mis;
   assign pwm_out = pwm_q;

   function addr_known;
      input [11:0] a;
      begin
         addr_known = (a[1:0] == 2'h0) && (a <= `SPTMR_BR_OFF) &&
            (a != 12'h010) && (a != 12'h014);
      end
   endfunction

   // two-flop synchroniser; only the second stage feeds edge detection
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
         prev_q <= 2'h0;
      end else begin
         sync1_q <= ccp_in;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // per-half datapath; one loop body serves both halves
   reg [CW-1:0] cnt_d [0:1];
   reg [PW-1:0] pre_d [0:1];
   reg [CW-1:0] cap_d [0:1];
   reg [1:0] en_clr;
   reg [1:0] trig_d;
   reg [1:0] pwm_d;
   reg [10:0] set_ev;
   reg [1:0] ev_hit;
   integer n;
   reg rise, fall, tick, capm, pwmm, zero;
   reg [1:0] ev;

   always @* begin
      en_clr = 2'h0;
      trig_d = 2'h0;
      pwm_d = pwm_q;
      set_ev = 11'h000;
      ev_hit = 2'h0;
      rise = 1'b0;
      fall = 1'b0;
      tick = 1'b0;
      capm = 1'b0;
      pwmm = 1'b0;
      zero = 1'b0;
      ev = 2'h0;
      for (n = 0; n < 2; n = n + 1) begin
         cnt_d[n] = cnt_q[n];
         pre_d[n] = pre_q[n];
         cap_d[n] = cap_q[n];
         rise = sync2_q[n] & ~prev_q[n];
         fall = ~sync2_q[n] & prev_q[n];
         ev = ctl_q[n][`SPTMR_CTL_EV_LO+1:`SPTMR_CTL_EV_LO];
         ev_hit[n] = (ev == `SPTMR_EV_RISE) ? rise :
            (ev == `SPTMR_EV_FALL) ? fall :
            (ev == `SPTMR_EV_BOTH) ? (rise | fall) : 1'b0;
         pwmm = mode_q[n][`SPTMR_MR_AMS];
         capm = (mode_q[n][1:0] == `SPTMR_MODE_CAPTURE) && !pwmm;
         zero = (cnt_q[n] == {CW{1'b0}});
         if (ilr_new_q[n]) begin
            cnt_d[n] = ilr_q[n];
            pre_d[n] = pr_q[n];
         end else if (split && ctl_q[n][`SPTMR_CTL_EN] && !ctl_q[n][`SPTMR_CTL_STALL]) begin
            if (capm && !mode_q[n][`SPTMR_MR_CMR]) begin
               if (ev_hit[n]) begin
                  if ((cnt_q[n] - 1'b1) == match_q[n] || cnt_q[n] == match_q[n]) begin
                     cnt_d[n] = ilr_q[n];
                     en_clr[n] = 1'b1;
                     set_ev[n*8+`SPTMR_ST_CM] = 1'b1;
                  end else begin
                     cnt_d[n] = cnt_q[n] - 1'b1;
                  end
               end
            end else begin
               // prescaler: advance main count once per pr+1 clocks
               tick = (pre_q[n] == {PW{1'b0}});
               pre_d[n] = tick ? pr_q[n] : pre_q[n] - 1'b1;
               if (capm && ev_hit[n]) begin
                  cap_d[n] = cnt_q[n];
                  set_ev[n*8+`SPTMR_ST_CE] = 1'b1;
               end
               if (tick) begin
                  if (zero) begin
                     cnt_d[n] = ilr_q[n];
                     if (!capm && !pwmm) begin
                        set_ev[n*8+`SPTMR_ST_TO] = 1'b1;
                        trig_d[n] = ctl_q[n][`SPTMR_CTL_OTE];
                        en_clr[n] = (mode_q[n][1:0] == `SPTMR_MODE_ONESHOT);
                     end
                  end else begin
                     cnt_d[n] = cnt_q[n] - 1'b1;
                  end
               end
            end
            if (pwmm) begin
               // prescale match must also agree when a prescaler is in use
               if (cnt_q[n] == ilr_q[n] && pre_q[n] == pr_q[n])
                  pwm_d[n] = ~ctl_q[n][`SPTMR_CTL_PWML];
               else if (cnt_q[n] == match_q[n] && pre_q[n] == pmr_q[n])
                  pwm_d[n] = ctl_q[n][`SPTMR_CTL_PWML];
            end
         end
         // outside edge time and PWM modes the readable count follows the counter, enabled or not,
         // so a reload after a count match or a load write is visible at once
         if (!pwmm && !(capm && mode_q[n][`SPTMR_MR_CMR]))
            cap_d[n] = cnt_d[n];
         if (!pwmm)
            pwm_d[n] = ctl_q[n][`SPTMR_CTL_PWML];
      end
   end

   wire [31:0] ctl_w = {16'h0000, ctl_q[1], ctl_q[0]};
   integer k;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= 3'h0;
         ris_q <= 11'h000;
         imr_q <= 11'h000;
         ilr_new_q <= 2'h0;
         pwm_q <= 2'h0;
         trig_out <= 2'h0;
         for (k = 0; k < 2; k = k + 1) begin
            mode_q[k] <= 4'h0;
            ctl_q[k] <= 8'h00;
            ilr_q[k] <= `SPTMR_CNT_RST;
            match_q[k] <= {CW{1'b1}};
            pr_q[k] <= `SPTMR_PRE_RST;
            pmr_q[k] <= `SPTMR_PRE_RST;
            cnt_q[k] <= `SPTMR_CNT_RST;
            pre_q[k] <= `SPTMR_PRE_RST;
            cap_q[k] <= `SPTMR_CNT_RST;
         end
      end else begin
         trig_out <= trig_d;
         pwm_q <= pwm_d;
         ilr_new_q <= 2'h0;
         for (k = 0; k < 2; k = k + 1) begin
            cnt_q[k] <= cnt_d[k];
            pre_q[k] <= pre_d[k];
            cap_q[k] <= cap_d[k];
            if (en_clr[k])
               ctl_q[k][`SPTMR_CTL_EN] <= 1'b0;
         end
         // hardware set wins over a same-cycle clear
         ris_q <= (wr && paddr == `SPTMR_ICR_OFF) ? ((ris_q & ~pwdata[10:0]) | set_ev) :
            (ris_q | set_ev);
         if (wr) begin
            case (paddr)
               `SPTMR_CFG_OFF: cfg_q <= pwdata[2:0];
               `SPTMR_AMODE_OFF: mode_q[0] <= pwdata[3:0];
               `SPTMR_BMODE_OFF: mode_q[1] <= pwdata[3:0];
               `SPTMR_CTL_OFF: begin
                  ctl_q[0] <= pwdata[7:0];
                  ctl_q[1] <= pwdata[15:8];
               end
               `SPTMR_IMR_OFF: imr_q <= pwdata[10:0];
               `SPTMR_AILR_OFF: begin
                  ilr_q[0] <= pwdata[CW-1:0];
                  ilr_new_q[0] <= 1'b1;
               end
               `SPTMR_BILR_OFF: begin
                  ilr_q[1] <= pwdata[CW-1:0];
                  ilr_new_q[1] <= 1'b1;
               end
               `SPTMR_AMATCH_OFF: match_q[0] <= pwdata[CW-1:0];
               `SPTMR_BMATCH_OFF: match_q[1] <= pwdata[CW-1:0];
               `SPTMR_APR_OFF: pr_q[0] <= pwdata[PW-1:0];
               `SPTMR_BPR_OFF: pr_q[1] <= pwdata[PW-1:0];
               `SPTMR_APMR_OFF: pmr_q[0] <= pwdata[PW-1:0];
               `SPTMR_BPMR_OFF: pmr_q[1] <= pwdata[PW-1:0];
               default: begin
               end
            endcase
         end
      end
   end

   always @* begin
      prdata = 32'h00000000;
      if (psel && !pwrite && addr_known(paddr)) begin
         case (paddr)
            `SPTMR_CFG_OFF: prdata = {29'h0, cfg_q};
            `SPTMR_AMODE_OFF: prdata = {28'h0, mode_q[0]};
            `SPTMR_BMODE_OFF: prdata = {28'h0, mode_q[1]};
            `SPTMR_CTL_OFF: prdata = ctl_w;
            `SPTMR_IMR_OFF: prdata = {21'h0, imr_q};
            `SPTMR_RIS_OFF: prdata = {21'h0, ris_q};
            `SPTMR_MIS_OFF: prdata = {21'h0, mis};
            `SPTMR_AILR_OFF: prdata = {16'h0, ilr_q[0]};
            `SPTMR_BILR_OFF: prdata = {16'h0, ilr_q[1]};
            `SPTMR_AMATCH_OFF: prdata = {16'h0, match_q[0]};
            `SPTMR_BMATCH_OFF: prdata = {16'h0, match_q[1]};
            `SPTMR_APR_OFF: prdata = {24'h0, pr_q[0]};
            `SPTMR_BPR_OFF: prdata = {24'h0, pr_q[1]};
            `SPTMR_APMR_OFF: prdata = {24'h0, pmr_q[0]};
            `SPTMR_BPMR_OFF: prdata = {24'h0, pmr_q[1]};
            `SPTMR_AR_OFF: prdata = {16'h0, cap_q[0]};
            `SPTMR_BR_OFF: prdata = {16'h0, cap_q[1]};
            default: prdata = 32'h00000000;
         endcase
      end
   end
endmodule // sptmr_timer

// ==== testbench/sptmr_pin_model.sv ====
/* sptmr_pin_model.sv: far-side source of capture pin edges, same edges on both halves.
 Assumes toggles stable while start is high and gap stable while busy; pins idle low after reset. */
`timescale 1ns/1ns
module sptmr_pin_model (
   input wire pclk,
   input wire presetn,
   input wire start,
   input wire [7:0] toggles,
   input wire [7:0] gap,
   output reg [1:0] capture_compare_pin,
   output reg busy
);
   reg [7:0] left_q;
   reg [7:0] wait_q;
   // gap sets prompt or slow edges; one clock or more keeps each edge apart
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_compare_pin <= 2'h0;
         busy <= 1'b0;
         left_q <= 8'h00;
         wait_q <= 8'h00;
      end else if (start && !busy) begin
         busy <= 1'b1;
         left_q <= toggles;
         wait_q <= gap;
      end else if (busy && wait_q != 8'h00) begin
         wait_q <= wait_q - 8'h01;
      end else if (busy && left_q == 8'h00) begin
         busy <= 1'b0;
      end else if (busy) begin
         capture_compare_pin <= ~capture_compare_pin;
         left_q <= left_q - 8'h01;
         wait_q <= gap;
      end
   end
endmodule // sptmr_pin_model

// ==== testbench/sptmr_timer_checker.sv ====
/* sptmr_timer_checker.sv: port-level assertions on the split timer.
 Assumes a bind onto sptmr_timer; control and raw status are shadowed from APB traffic. */
`timescale 1ns/1ns
module sptmr_chk (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [1:0] ccp_in,
   input wire [1:0] pwm_out,
   input wire [1:0] trig_out,
   input wire irq
);
   wire rd = psel && penable && !pwrite;
   wire wr = psel && penable && pwrite;
   reg [15:0] ctl_q;
   reg [10:0] ris_q;
   // status seen set stays a floor until software clears those bits
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= 16'h0000;
         ris_q <= 11'h000;
      end else if (wr && paddr == 12'h00C) begin
         ctl_q <= pwdata[15:0];
      end else if (wr && paddr == 12'h024) begin
         ris_q <= ris_q & ~pwdata[10:0];
      end else if (rd && paddr == 12'h01C) begin
         ris_q <= prdata[10:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_trig_a_pulse: assert property (trig_out[0] |=> !trig_out[0])
      else $error("trigger a too long");
   a_trig_b_pulse: assert property (trig_out[1] |=> !trig_out[1])
      else $error("trigger b too long");
   a_trig_a_gate: assert property (trig_out[0] |-> $past(ctl_q[5]) || $past(ctl_q[5], 2))
      else $error("trigger a not enabled");
   a_trig_b_gate: assert property (trig_out[1] |-> $past(ctl_q[13]) || $past(ctl_q[13], 2))
      else $error("trigger b not enabled");
   a_irq_masked: assert property (rd && paddr == 12'h020 |-> irq == (|prdata[10:0]))
      else $error("irq disagrees with masked status");
   a_raw_held: assert property (rd && paddr == 12'h01C |-> (prdata[10:0] & ris_q) == ris_q)
      else $error("raw flag lost without clear");
   a_zero_wait: assert property (psel |-> pready && !pslverr)
      else $error("wait or error on bus");
   a_unmapped_zero: assert property (rd && paddr == 12'h050 |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   cover property (trig_out[1] ##12 trig_out[1]);
   cover property (rd && paddr == 12'h01C && prdata[9]);
   cover property ($rose(pwm_out[0]));
endmodule // sptmr_chk
bind sptmr_timer sptmr_chk u_sptmr_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .ccp_in(ccp_in), .pwm_out(pwm_out),
   .trig_out(trig_out), .irq(irq));

// ==== testbench/sptmr_timer_tb.sv ====
/* sptmr_timer_tb.sv: self-checking bench for the split timer over APB.
 Assumes sptmr_timer, sptmr_pin_model and the bound checker; reads checked from a queue. */
`timescale 1ns/1ns
module sptmr_timer_tb;
   reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0, lfsr = 32'hD163;
   reg [7:0] tog = 8'h00, gap = 8'h01;
   wire [31:0] prdata;
   wire pready, pslverr, irq, busy;
   wire [1:0] capture_compare_pin, pwm_out, trig_out;
   logic [31:0] expq[$];
   int miscompares = 0, tests_run = 0, n, c1, c2;
   always #25 pclk = ~pclk;
   sptmr_timer u_sptmr_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ccp_in(capture_compare_pin), .pwm_out(pwm_out), .trig_out(trig_out), .irq(irq));
   sptmr_pin_model u_sptmr_pin_model (.pclk(pclk), .presetn(presetn), .start(go),
      .toggles(tog), .gap(gap), .capture_compare_pin(capture_compare_pin), .busy(busy));
   function [31:0] nxt(input [31:0] s);
      nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task stop_test;
      begin
         $display("tests_run %0d miscompares %0d", tests_run, miscompares);
         if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] v, input [31:0] e);
      begin
         tests_run++;
         if (v !== e) begin
            miscompares++;
            $display("Error %0t: saw %h want %h", $time, v, e);
         end
      end
   endtask
   // k: 0/1 trigger of a half, 2 pin model idle, 3 bus ready
   task hold(input [1:0] k);
      begin
         n = 0;
         @(posedge pclk);
         while (!(k[1] ? (k[0] ? pready === 1'b1 : busy === 1'b0) : trig_out[k[0]] === 1'b1)
               && n < 600) begin
            @(posedge pclk);
            n++;
         end
         if (n == 600) begin
            miscompares++;
            stop_test;
         end
      end
   endtask
   task ap(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         if (!w)
            expq.push_back(d);
         @(posedge pclk);
         penable <= 1'b1;
         hold(2'h3);
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task wt(input [11:0] a, input [31:0] d);
      ap(1'b1, a, d);
   endtask
   task rd(input [11:0] a, input [31:0] e);
      ap(1'b0, a, e);
   endtask
   // trailing wait covers the three-clock synchroniser latency
   task pins(input [7:0] t, input [7:0] g);
      begin
         tog <= t;
         gap <= g;
         go <= 1'b1;
         @(posedge pclk);
         go <= 1'b0;
         @(posedge pclk);
         hold(2'h2);
         repeat (4) @(posedge pclk);
      end
   endtask
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready)
         chk(prdata, expq.pop_front());
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h048, 32'hFFFF);
      rd(12'h03C, 32'h0);
      rd(12'h050, 32'h0);
      wt(12'h000, 32'h4);
      wt(12'h004, 32'h1);
      lfsr = nxt(lfsr);
      wt(12'h028, {16'h0, lfsr[15:0]});
      rd(12'h048, {16'h0, lfsr[15:0]});
      $display("test reset done");
      wt(12'h008, 32'h2);
      wt(12'h038, 32'h1);
      wt(12'h03C, 32'h1);
      wt(12'h028, 32'h5);
      wt(12'h02C, 32'h5);
      wt(12'h018, 32'h1);
      wt(12'h00C, 32'h2121);
      hold(2'h1);
      hold(2'h1);
      chk(n + 1, 32'hC);
      rd(12'h00C, 32'h2120);
      rd(12'h01C, 32'h101);
      rd(12'h020, 32'h1);
      wt(12'h024, 32'h1);
      rd(12'h01C, 32'h100);
      wt(12'h00C, 32'h300);
      wt(12'h02C, 32'h5);
      repeat (4) @(posedge pclk);
      rd(12'h04C, 32'h5);
      wt(12'h00C, 32'h0);
      $display("test timer done");
      wt(12'h024, 32'h707);
      wt(12'h038, 32'h0);
      wt(12'h03C, 32'h0);
      wt(12'h004, 32'h3);
      wt(12'h008, 32'h3);
      wt(12'h028, 32'hA);
      wt(12'h02C, 32'hA);
      wt(12'h030, 32'h6);
      wt(12'h034, 32'h6);
      wt(12'h018, 32'h2);
      wt(12'h00C, 32'hD0D);
      pins(8'h06, 8'h01);
      rd(12'h01C, 32'h202);
      rd(12'h020, 32'h2);
      rd(12'h00C, 32'hC0C);
      rd(12'h04C, 32'hA);
      wt(12'h030, 32'h9);
      wt(12'h034, 32'h9);
      for (int e = 0; e < 2; e++) begin
         wt(12'h024, 32'h707);
         wt(12'h00C, {20'h0, e[1:0], 2'h1, 4'h0, e[1:0], 2'h1});
         pins(8'h01, 8'h06);
         rd(12'h01C, 32'h202);
      end
      $display("test edge count done");
      wt(12'h024, 32'h707);
      wt(12'h004, 32'h7);
      wt(12'h008, 32'h7);
      wt(12'h00C, 32'h101);
      pins(8'h01, 8'h02);
      rd(12'h01C, 32'h404);
      wt(12'h024, 32'h707);
      pins(8'h01, 8'h02);
      rd(12'h01C, 32'h0);
      wt(12'h00C, 32'h0);
      $display("test edge time done");
      wt(12'h004, 32'hA);
      wt(12'h008, 32'hA);
      wt(12'h028, 32'h7);
      wt(12'h02C, 32'h7);
      wt(12'h030, 32'h2);
      wt(12'h034, 32'h2);
      wt(12'h00C, 32'h4101);
      repeat (16) @(posedge pclk);
      c1 = 0;
      c2 = 0;
      repeat (32) begin
         @(posedge pclk);
         c1 += pwm_out[0];
         c2 += pwm_out[1];
      end
      chk(c1, 32'h14);
      chk(c2, 32'hC);
      rd(12'h01C, 32'h0);
      $display("test pwm done");
      stop_test;
   end
endmodule // sptmr_timer_tb
